// File: common/dtps_pkg.sv
// Constants and types for the dual-thread program scheduler.
// Assumes a 20 MHz system clock and an interpreter that decodes commands.
//
// Functional notes
// - Reset starts primary thread only, all commands
// - Launch carries buffer size and storage address
// - Launch removes allocation plus one word
// - Secondary program counter zero is region start
// - Both active: alternate 120 us slots
// - Secondary thread barred from motion commands
// - Secondary barred from launch or reallocation
// - Secondary may use registers, IO, CAN
// - Private accumulators; secondary one seen at 248
// - Separate zero/negative/positive flags per thread
// - Status word two bit 11 shows secondary
// - Extended recovery reacts to secondary thread loss
// - Unmasked fault events stop the secondary thread
// - Secondary may force primary onto new program
// - Secondary ends on primary stop or its own end
// - Stopped secondary returns slot and buffer space
// - Primary-only command in secondary gives error 17
// - Other secondary errors offset by 64
// - Clear status clears the one shared register
// - One delay counter shared by both threads
// - Count-up 244 and count-down 245 timers readable
package dtps_pkg;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SLOT_US = 120;
  localparam int unsigned PERIOD_US = 240;
  localparam int unsigned MS_UNIT = 1;
  localparam logic [11:0] SLOT_CYC = 12'(SLOT_US * (CLK_HZ / 1_000_000));
  localparam int unsigned MS_CYC_DEF = MS_UNIT * (CLK_HZ / 1_000);

  // ******************************************************************
  // Buffer, registers, error codes
  // ******************************************************************
  localparam logic [11:0] PROG_BUF_WORDS = 12'h0400;
  localparam logic [11:0] ALLOC_EXTRA = 12'h001;
  localparam logic [7:0] ACC_IDX = 8'h0a;
  localparam logic [7:0] SEC_ACC_IDX = 8'hf8;
  localparam logic [7:0] UP_TMR_IDX = 8'hf4;
  localparam logic [7:0] DN_TMR_IDX = 8'hf5;
  localparam int unsigned STS2_SEC_BIT = 11;
  localparam logic [6:0] ERR_SEC_ONLY = 7'h11;
  localparam logic [6:0] ERR_SEC_OFS = 7'h40;
  localparam logic [5:0] KILL_MASK_RST = 6'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic {
    THR_PRI = 1'b0,
    THR_SEC = 1'b1
  } dtps_thread_t;

  typedef enum logic {
    SEC_IDLE = 1'b0,
    SEC_RUN = 1'b1
  } dtps_sec_state_t;

  // One decoded command from the interpreter
  typedef struct packed {
    logic valid;
    logic motion;
    logic launch;
    logic alloc_chg;
    logic end_prog;
    logic stop_sec;
    logic force_pri;
    logic clr_status;
  } dtps_cmd_t;

  // Fault events: kill, over-volt, drv under-volt, cpu under-volt, halt, stop
  typedef struct packed {
    logic kill_motor;
    logic over_volt;
    logic uv_driver;
    logic uv_proc;
    logic halt;
    logic stop;
  } dtps_kill_t;

endpackage

// File: design/dtps_sched.sv
// Dual-thread program scheduler: time slices, thread limits, private
// accumulators and flags, shared status, delay counter and timers.
// Assumes the interpreter gives decoded commands tagged with their thread.
module dtps_sched #(
  parameter int unsigned MS_CYC = dtps_pkg::MS_CYC_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire dtps_pkg::dtps_cmd_t cmd_i,
  input wire dtps_pkg::dtps_thread_t cmd_thread_i,
  input wire logic [11:0] launch_size_i,
  input wire logic [15:0] launch_nv_addr_i,
  input wire logic [15:0] force_nv_addr_i,
  input wire logic err_valid_i,
  input wire logic [6:0] err_code_i,
  input wire dtps_pkg::dtps_kill_t kill_ev_i,
  input wire logic kill_mask_wr_i,
  input wire logic [5:0] kill_mask_i,
  input wire logic ext_recov_wr_i,
  input wire logic ext_recov_en_i,
  input wire logic acc_wr_i,
  input wire logic [31:0] acc_wdata_i,
  input wire logic flags_wr_i,
  input wire logic [2:0] flags_i,
  input wire dtps_pkg::dtps_thread_t rd_thread_i,
  input wire logic [7:0] rd_idx_i,
  input wire logic [11:0] sec_pc_i,
  input wire logic delay_load_i,
  input wire logic [31:0] delay_ms_i,
  input wire logic dn_tmr_wr_i,
  input wire logic [31:0] dn_tmr_wdata_i,
  output dtps_pkg::dtps_thread_t slot_thread_o,
  output logic slot_start_o,
  output logic cmd_reject_o,
  output logic err_valid_o,
  output logic [6:0] err_code_o,
  output logic sec_active_o,
  output logic sec_load_o,
  output logic [15:0] sec_nv_addr_o,
  output logic [11:0] pri_buf_limit_o,
  output logic [11:0] sec_phys_addr_o,
  output logic pri_restart_o,
  output logic [15:0] pri_nv_addr_o,
  output logic pri_recovery_o,
  output logic [15:0] status_two_o,
  output logic [31:0] rd_data_o,
  output logic rd_hit_o,
  output logic [2:0] flags_o,
  output logic delay_busy_o
);
  import dtps_pkg::*;

  // ******************************************************************
  // Command qualification
  // ******************************************************************
  // Commands issued by the secondary thread are screened before any effect
  wire logic from_sec = cmd_i.valid && (cmd_thread_i == THR_SEC);
  wire logic from_pri = cmd_i.valid && (cmd_thread_i == THR_PRI);
  wire logic sec_barred = from_sec && (cmd_i.motion || cmd_i.launch || cmd_i.alloc_chg);
  wire logic sec_ok = from_sec && !sec_barred;
  wire logic kill_hit;
  wire logic sec_stop;
  wire logic do_launch;

  dtps_sec_state_t sec_q, sec_d;
  dtps_thread_t slot_q, slot_d;
  logic [11:0] slot_cnt_q, slot_cnt_d;
  logic [11:0] alloc_q;
  logic [5:0] kill_mask_q;
  logic ext_recov_q;

  // ******************************************************************
  // Secondary thread lifetime
  // ******************************************************************
  // Masked bits are events the secondary survives; default kills on all
  assign kill_hit = |(kill_ev_i & ~kill_mask_q);
  assign sec_stop = (sec_q == SEC_RUN) &&
    (kill_hit || (from_pri && cmd_i.stop_sec) || (sec_ok && cmd_i.end_prog));
  // A launch while one already runs is ignored to keep the allocation fixed
  assign do_launch = from_pri && cmd_i.launch && (sec_q == SEC_IDLE);

  // Next state of the secondary thread
  always_comb begin
    sec_d = sec_q;
    case (sec_q)
      SEC_IDLE: begin
        if (do_launch) begin
          sec_d = SEC_RUN;
        end
      end
      SEC_RUN: begin
        if (sec_stop) begin
          sec_d = SEC_IDLE;
        end
      end
      default: begin
        sec_d = SEC_IDLE;
      end
    endcase
  end

  // Reset leaves only the primary thread alive
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_q <= SEC_IDLE;
    end else begin
      sec_q <= sec_d;
    end
  end

  // Launch parameters and kill configuration
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alloc_q <= 12'h000;
      sec_nv_addr_o <= 16'h0000;
      sec_load_o <= 1'b0;
      kill_mask_q <= KILL_MASK_RST;
      ext_recov_q <= 1'b0;
    end else begin
      // One-cycle request to fetch the secondary program from storage
      sec_load_o <= do_launch;
      if (do_launch) begin
        alloc_q <= launch_size_i;
        sec_nv_addr_o <= launch_nv_addr_i;
      end
      if (kill_mask_wr_i) begin
        kill_mask_q <= kill_mask_i;
      end
      if (ext_recov_wr_i) begin
        ext_recov_q <= ext_recov_en_i;
      end
    end
  end

  assign sec_active_o = (sec_q == SEC_RUN);

  // ******************************************************************
  // Buffer carving
  // ******************************************************************
  // The extra word sits between the two regions; no check that the size fits
  wire logic [11:0] carve = alloc_q + ALLOC_EXTRA;
  assign pri_buf_limit_o = sec_active_o ? (PROG_BUF_WORDS - carve) : PROG_BUF_WORDS;
  assign sec_phys_addr_o = PROG_BUF_WORDS - alloc_q + sec_pc_i;

  // ******************************************************************
  // Time slices
  // ******************************************************************
  wire logic slot_end = (slot_cnt_q == SLOT_CYC - 12'h001);

  // Slot timer and thread selection
  always_comb begin
    slot_d = slot_q;
    slot_cnt_d = slot_end ? 12'h000 : slot_cnt_q + 12'h001;
    if (sec_d == SEC_IDLE) begin
      slot_d = THR_PRI;
    end else if (slot_end) begin
      slot_d = (slot_q == THR_PRI) ? THR_SEC : THR_PRI;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_q <= THR_PRI;
      slot_cnt_q <= 12'h000;
      slot_start_o <= 1'b0;
    end else begin
      slot_q <= slot_d;
      slot_cnt_q <= slot_cnt_d;
      slot_start_o <= slot_end;
    end
  end

  assign slot_thread_o = slot_q;

  // ******************************************************************
  // Errors and cross-thread control
  // ******************************************************************
  // Barred command wins over a concurrent interpreter error
  wire logic [6:0] err_sel = sec_barred ? ERR_SEC_ONLY :
    (from_sec ? (err_code_i | ERR_SEC_OFS) : err_code_i);
  wire logic err_any = sec_barred || err_valid_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_valid_o <= 1'b0;
      err_code_o <= 7'h00;
      pri_restart_o <= 1'b0;
      pri_nv_addr_o <= 16'h0000;
      pri_recovery_o <= 1'b0;
    end else begin
      err_valid_o <= err_any;
      if (err_any) begin
        err_code_o <= err_sel;
      end
      pri_restart_o <= sec_ok && cmd_i.force_pri;
      if (sec_ok && cmd_i.force_pri) begin
        pri_nv_addr_o <= force_nv_addr_i;
      end
      pri_recovery_o <= sec_stop && ext_recov_q;
    end
  end

  assign cmd_reject_o = sec_barred;

  // ******************************************************************
  // Shared status word two
  // ******************************************************************
  logic [5:0] sts_q;
  wire logic clr_sts = (from_pri || sec_ok) && cmd_i.clr_status;

  // Sticky event bits; a new event in the clearing cycle survives
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sts_q <= 6'h00;
    end else begin
      sts_q <= (clr_sts ? 6'h00 : sts_q) | kill_ev_i;
    end
  end

  assign status_two_o = {4'h0, sec_active_o, 5'h00, sts_q};

  // ******************************************************************
  // Per-thread accumulator and condition flags
  // ******************************************************************
  logic [31:0] acc_q [2];
  logic [2:0] flg_q [2];

  // Each thread writes only its own copy
  for (genvar t = 0; t < 2; t++) begin : g_thr
    wire logic mine = (cmd_thread_i == dtps_thread_t'(t));
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        acc_q[t] <= WORD_RST;
        flg_q[t] <= 3'h0;
      end else begin
        if (acc_wr_i && mine) begin
          acc_q[t] <= acc_wdata_i;
        end
        if (flags_wr_i && mine) begin
          flg_q[t] <= flags_i;
        end
      end
    end
  end

  assign flags_o = flg_q[cmd_thread_i];

  // ******************************************************************
  // Shared delay counter and free timers
  // ******************************************************************
  logic [31:0] ms_cnt_q;
  logic [31:0] delay_q;
  logic [31:0] up_q;
  logic [31:0] dn_q;
  wire logic ms_tick = (ms_cnt_q == 32'(MS_CYC - 1));

  // One counter for all delay commands, whichever thread loads it last
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt_q <= WORD_RST;
      delay_q <= WORD_RST;
      up_q <= WORD_RST;
      dn_q <= WORD_RST;
    end else begin
      ms_cnt_q <= ms_tick ? WORD_RST : ms_cnt_q + 32'h0000_0001;
      if (delay_load_i) begin
        delay_q <= delay_ms_i;
      end else if (ms_tick && delay_q != WORD_RST) begin
        delay_q <= delay_q - 32'h0000_0001;
      end
      if (ms_tick) begin
        up_q <= up_q + 32'h0000_0001;
      end
      if (dn_tmr_wr_i) begin
        dn_q <= dn_tmr_wdata_i;
      end else if (ms_tick && dn_q != WORD_RST) begin
        dn_q <= dn_q - 32'h0000_0001;
      end
    end
  end

  assign delay_busy_o = (delay_q != WORD_RST);

  // ******************************************************************
  // Register read port
  // ******************************************************************
  // Index 10 resolves to the reader's own accumulator
  assign rd_data_o = (rd_idx_i == ACC_IDX) ? acc_q[rd_thread_i] :
    (rd_idx_i == SEC_ACC_IDX) ? acc_q[THR_SEC] :
    (rd_idx_i == UP_TMR_IDX) ? up_q :
    (rd_idx_i == DN_TMR_IDX) ? dn_q : WORD_RST;
  assign rd_hit_o = (rd_idx_i == ACC_IDX) || (rd_idx_i == SEC_ACC_IDX) ||
    (rd_idx_i == UP_TMR_IDX) || (rd_idx_i == DN_TMR_IDX);

  // ******************************************************************
  // Assertions
  // ******************************************************************
  pri_only_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !sec_active_o |-> slot_thread_o == THR_PRI)
    else $error("slot given to idle secondary thread");

  slot_alt_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (slot_end && sec_active_o && $past(sec_active_o) && sec_d == SEC_RUN) |=>
    slot_thread_o != $past(slot_thread_o))
    else $error("slots did not alternate");

  slot_len_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    slot_cnt_q < SLOT_CYC)
    else $error("slot counter past slot length");

  barred_err_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sec_barred |=> err_valid_o && err_code_o == 7'h11)
    else $error("barred command not flagged with code 17");

  sec_err_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (from_sec && !sec_barred && err_valid_i) |=>
    err_code_o == ($past(err_code_i) | 7'h40))
    else $error("secondary error not offset by 64");

  buf_carve_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(sec_active_o) |-> pri_buf_limit_o == PROG_BUF_WORDS - $past(launch_size_i) - 12'h001)
    else $error("carved space not size plus one");

  buf_return_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(sec_active_o) |-> pri_buf_limit_o == PROG_BUF_WORDS)
    else $error("buffer not returned on stop");

  kill_stop_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (sec_active_o && kill_hit) |=> !sec_active_o && status_two_o[STS2_SEC_BIT] == 1'b0)
    else $error("unmasked event did not stop secondary");

  // The pulse reflects the enable as it stood in the stopping cycle
  recov_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(sec_active_o) |-> pri_recovery_o == $past(ext_recov_q))
    else $error("recovery pulse does not follow secondary loss");

  sts_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (clr_sts && kill_ev_i.halt) |=> sts_q[1])
    else $error("event lost in clearing cycle");

  acc_priv_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (acc_wr_i && cmd_thread_i == THR_PRI) |=> $stable(acc_q[THR_SEC]))
    else $error("primary write touched secondary accumulator");

  sec_load_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    do_launch |=> sec_load_o && sec_nv_addr_o == $past(launch_nv_addr_i))
    else $error("launch did not request program load");

endmodule

// File: dv/tb.sv
// Self-checking bench for the dual-thread program scheduler.
// Assumes dtps_pkg is compiled first; the bench drives every port itself.
module tb
  import dtps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ******************************************************************
  // Stimulus and observed signals
  // ******************************************************************
  localparam int unsigned MSC = 20;
  localparam int B_MOT = 6;
  localparam int B_LAU = 5;
  localparam int B_ALC = 4;
  localparam int B_END = 3;
  localparam int B_STP = 2;
  localparam int B_FRC = 1;
  localparam int B_CLR = 0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  dtps_cmd_t cmd = '0;
  dtps_thread_t thr = THR_PRI;
  dtps_thread_t rthr = THR_PRI;
  dtps_kill_t kev = '0;
  logic [11:0] lsize = 12'h000;
  logic [11:0] spc = 12'h000;
  logic [15:0] lnv = 16'h0000;
  logic [15:0] fnv = 16'h0000;
  logic erri = 1'b0;
  logic [6:0] errin = 7'h00;
  logic kmwr = 1'b0;
  logic [5:0] kmask = 6'h00;
  logic erwr = 1'b0;
  logic eren = 1'b0;
  logic accwr = 1'b0;
  logic [31:0] accd = 32'h0000_0000;
  logic flwr = 1'b0;
  logic [2:0] flin = 3'h0;
  logic [7:0] ridx = 8'h00;
  logic dload = 1'b0;
  logic [31:0] dms = 32'h0000_0000;
  logic dnwr = 1'b0;
  logic [31:0] dnd = 32'h0000_0000;
  dtps_thread_t slot_thr;
  logic slot_st, rej, errv, sact, prst, prec, rhit, dbusy, sld;
  logic [6:0] errc;
  logic [15:0] snv, pnv, sts;
  logic [11:0] plim, sphys;
  logic [31:0] rdd;
  logic [2:0] flg;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int rec_cnt = 0;
  int rst_cnt = 0;
  int ld_cnt = 0;

  // Small millisecond count keeps timer tests short
  dtps_sched #(.MS_CYC(MSC)) uut (
    .clk_sys_i(clk), .rst_n_i(rst_n), .cmd_i(cmd), .cmd_thread_i(thr),
    .launch_size_i(lsize), .launch_nv_addr_i(lnv), .force_nv_addr_i(fnv),
    .err_valid_i(erri), .err_code_i(errin), .kill_ev_i(kev), .kill_mask_wr_i(kmwr),
    .kill_mask_i(kmask), .ext_recov_wr_i(erwr), .ext_recov_en_i(eren),
    .acc_wr_i(accwr), .acc_wdata_i(accd), .flags_wr_i(flwr), .flags_i(flin),
    .rd_thread_i(rthr), .rd_idx_i(ridx), .sec_pc_i(spc), .delay_load_i(dload),
    .delay_ms_i(dms), .dn_tmr_wr_i(dnwr), .dn_tmr_wdata_i(dnd),
    .slot_thread_o(slot_thr), .slot_start_o(slot_st), .cmd_reject_o(rej),
    .err_valid_o(errv), .err_code_o(errc), .sec_active_o(sact), .sec_load_o(sld),
    .sec_nv_addr_o(snv), .pri_buf_limit_o(plim), .sec_phys_addr_o(sphys),
    .pri_restart_o(prst), .pri_nv_addr_o(pnv), .pri_recovery_o(prec),
    .status_two_o(sts), .rd_data_o(rdd), .rd_hit_o(rhit), .flags_o(flg),
    .delay_busy_o(dbusy)
  );

  // ******************************************************************
  // Clock, pulse counters and hang guard
  // ******************************************************************
  always #25 clk = ~clk;

  // One-cycle pulses are counted so their exact cycle need not be guessed
  always @(posedge clk) begin
    cyc++;
    if (prec === 1'b1) rec_cnt++;
    if (prst === 1'b1) rst_cnt++;
    if (sld === 1'b1) ld_cnt++;
    if (cyc == 30000) begin
      fail_count++;
      summarize();
    end
  end

  // ******************************************************************
  // Shared helpers
  // ******************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // A step returns 5 ns after a rising edge so drives stay clear of it
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  function automatic dtps_cmd_t mk(input int b);
    dtps_cmd_t c;
    c = '0;
    c.valid = 1'b1;
    c[b] = 1'b1;
    return c;
  endfunction

  // An idle cycle after each command keeps back-to-back strobes apart
  task automatic issue(input int b, input dtps_thread_t t);
    cmd = mk(b);
    thr = t;
    step(1);
    cmd = '0;
    step(1);
  endtask

  task automatic launch(input logic [11:0] n, input logic [15:0] a);
    lsize = n;
    lnv = a;
    issue(B_LAU, THR_PRI);
  endtask

  // Bounded wait for the next slot boundary pulse
  task automatic wait_start(output int n);
    n = 0;
    do begin
      step(1);
      n++;
    end while (slot_st !== 1'b1 && n < 5000);
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_idle();
    int n;
    chk(sact, 1'b0, "active after reset");
    chk(plim, 12'h400, "limit after reset");
    wait_start(n);
    chk(slot_thr, THR_PRI, "idle slot owner");
    wait_start(n);
    chk(slot_thr, THR_PRI, "idle slot owner");
    chk(sts[11], 1'b0, "status bit idle");
    $display("test idle done");
  endtask

  task automatic t_launch_slots();
    int n;
    dtps_thread_t t0;
    launch(12'h12c, 16'h0a5a);
    chk(sact, 1'b1, "launch active");
    chk(sts[11], 1'b1, "status bit run");
    chk(plim, 12'h2d3, "primary limit");
    chk(snv, 16'h0a5a, "storage address");
    chk(ld_cnt, 1, "load pulse");
    spc = 12'h005;
    #1 chk(sphys, 12'h2d9, "region offset");
    wait_start(n);
    t0 = slot_thr;
    wait_start(n);
    chk(n, 2400, "slot length");
    chk(slot_thr, (t0 == THR_PRI) ? THR_SEC : THR_PRI, "slot alternation");
    wait_start(n);
    chk(slot_thr, t0, "slot alternation");
    $display("test launch and slots done");
  endtask

  task automatic t_barred();
    int bar[3] = '{B_MOT, B_LAU, B_ALC};
    foreach (bar[i]) begin
      cmd = mk(bar[i]);
      thr = THR_SEC;
      #1 chk(rej, 1'b1, "refusal");
      step(1);
      chk(errv, 1'b1, "error pulse");
      chk(errc, 7'h11, "primary-only code");
    end
    cmd = mk(B_MOT);
    thr = THR_PRI;
    #1 chk(rej, 1'b0, "primary motion");
    step(1);
    cmd = '0;
    chk(plim, 12'h2d3, "allocation kept");
    // An interpreter error is tied to the command that raised it
    erri = 1'b1;
    errin = 7'h05;
    cmd.valid = 1'b1;
    thr = THR_SEC;
    step(1);
    chk(errc, 7'h45, "offset code");
    thr = THR_PRI;
    step(1);
    erri = 1'b0;
    cmd = '0;
    chk(errc, 7'h05, "primary code");
    $display("test barred done");
  endtask

  task automatic t_acc_force();
    int r0;
    accwr = 1'b1;
    flwr = 1'b1;
    accd = 32'h1111_2222;
    flin = 3'h4;
    step(1);
    thr = THR_SEC;
    accd = 32'h3333_4444;
    flin = 3'h1;
    step(1);
    accwr = 1'b0;
    flwr = 1'b0;
    ridx = 8'h0a;
    #1 chk(rdd, 32'h1111_2222, "primary acc");
    rthr = THR_SEC;
    #1 chk(rdd, 32'h3333_4444, "secondary acc");
    ridx = 8'hf8;
    rthr = THR_PRI;
    #1 chk(rdd, 32'h3333_4444, "mirror acc");
    chk(rhit, 1'b1, "mapped index");
    chk(flg, 3'h1, "secondary flags");
    thr = THR_PRI;
    #1 chk(flg, 3'h4, "primary flags");
    r0 = rst_cnt;
    fnv = 16'h0bcd;
    step(1);
    issue(B_FRC, THR_SEC);
    step(2);
    chk(rst_cnt, r0 + 1, "restart pulse");
    chk(pnv, 16'h0bcd, "restart address");
    $display("test accumulators and force done");
  endtask

  task automatic t_kill_stop();
    int r0;
    kev.halt = 1'b1;
    step(1);
    kev = '0;
    step(2);
    chk(sact, 1'b0, "default halt kill");
    chk(slot_thr, THR_PRI, "slot returned");
    chk(plim, 12'h400, "buffer returned");
    erwr = 1'b1;
    eren = 1'b1;
    kmwr = 1'b1;
    kmask = 6'h20;
    step(1);
    erwr = 1'b0;
    kmwr = 1'b0;
    launch(12'h010, 16'h0100);
    kev.kill_motor = 1'b1;
    step(1);
    kev = '0;
    step(2);
    chk(sact, 1'b1, "masked survives");
    r0 = rec_cnt;
    kev.over_volt = 1'b1;
    step(1);
    kev = '0;
    step(2);
    chk(sact, 1'b0, "unmasked kill");
    chk(rec_cnt, r0 + 1, "recovery pulse");
    chk(sts[5:0], 6'h32, "sticky events");
    issue(B_CLR, THR_SEC);
    chk(sts[5:0], 6'h00, "status cleared");
    // An event in the clearing cycle must survive the clear
    cmd = mk(B_CLR);
    thr = THR_PRI;
    kev.halt = 1'b1;
    step(1);
    cmd = '0;
    kev = '0;
    step(1);
    chk(sts[5:0], 6'h02, "set wins over clear");
    issue(B_CLR, THR_PRI);
    chk(sts[5:0], 6'h00, "primary clear");
    launch(12'h010, 16'h0100);
    issue(B_END, THR_SEC);
    chk(sact, 1'b0, "end stops");
    chk(rec_cnt, r0 + 2, "recovery on end");
    erwr = 1'b1;
    eren = 1'b0;
    step(1);
    erwr = 1'b0;
    launch(12'h010, 16'h0100);
    issue(B_STP, THR_PRI);
    step(2);
    chk(sact, 1'b0, "primary stops");
    chk(rec_cnt, r0 + 2, "recovery disabled");
    $display("test kill and stop done");
  endtask

  task automatic t_timers();
    logic [31:0] v;
    dnwr = 1'b1;
    dnd = 32'h0000_0003;
    dload = 1'b1;
    dms = 32'h0000_0002;
    step(1);
    dnwr = 1'b0;
    dload = 1'b0;
    chk(dbusy, 1'b1, "delay busy");
    step(3 * MSC + 5);
    chk(dbusy, 1'b0, "delay expired");
    ridx = 8'hf5;
    #1 chk(rdd, 32'h0000_0000, "down timer stops");
    ridx = 8'hf4;
    #1 v = rdd;
    step(2 * MSC);
    rthr = THR_SEC;
    #1 chk(rdd, v + 2, "up timer");
    ridx = 8'h0b;
    #1 chk(rhit, 1'b0, "unmapped index");
    chk(rdd, 32'h0000_0000, "unmapped data");
    $display("test timers done");
  endtask

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    repeat (5) @(posedge clk);
    #5 rst_n = 1'b1;
    t_idle();
    t_launch_slots();
    t_barred();
    t_acc_force();
    t_kill_stop();
    t_timers();
    summarize();
  end
endmodule
